// file: core/rtb_map.vh
`ifndef RTB_MAP_VH
`define RTB_MAP_VH

// stage preset values
`define RTB_PRE_CHAR        4'h9
`define RTB_PRE_HALF        4'hE
`define RTB_PRE_THIRD       4'hB
`define RTB_PRE_LINE        4'h6
`define RTB_PRE_GROUP       4'h6
`define RTB_PRE_FRLOW       4'hE
`define RTB_PRE_FRHIGH60    4'h3
`define RTB_PRE_FRHIGH50    4'h2
`define RTB_FRHIGH50_HIT    4'h1

// horizontal zone edges, in third-stage carries within a line
`define RTB_HZ_ON           4'h8
`define RTB_HZ_OFF_ALPHA    4'hE
`define RTB_HZ_OFF_GRAPH    4'hD

// vertical zone, in scan lines after vertical sync
`define RTB_VZ_START        9'h014
`define RTB_VZ_LINES        9'h0C8

// last break tally value per burst
`define RTB_BRK_LAST32      6'h1F
`define RTB_BRK_LAST64      6'h3F

// synchronised pin vector positions
`define RTB_PIN_EXTCLK      0
`define RTB_PIN_OSCINH      1
`define RTB_PIN_RVSYNC      2
`define RTB_PIN_INIT        3
`define RTB_PIN_TP1         4
`define RTB_PIN_TP3         5
`define RTB_PIN_TP4         6
`define RTB_PIN_INTSTB      7
`define RTB_PIN_IOTLOAD     8
`define RTB_PIN_IOTGO       9
`define RTB_PIN_GRANT       10
`define RTB_PIN_MODE64      11
`define RTB_PIN_GRAPH       12
`define RTB_PIN_FIFTY       13
`define RTB_PIN_COUNT       14

`define RTB_DATA_W          12
`define RTB_EXT_LSB         6
`define RTB_EXT_MSB         8

`endif

// file: core/rtb_pin_sync.v
`timescale 1ns/1ps
module rtb_pin_sync #(
    parameter W = 1
) (
    clk,
    rst,
    pinIn,
    level,
    rise
);
    input  wire         clk;
    input  wire         rst;
    input  wire [W-1:0] pinIn;
    output wire [W-1:0] level;
    output wire [W-1:0] rise;

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : gBit
            reg ff1_r;
            reg ff2_r;
            reg ff3_r;
            always @(posedge clk) begin
                if (rst) begin
                    ff1_r <= 1'b0;
                    ff2_r <= 1'b0;
                    ff3_r <= 1'b0;
                end else begin
                    ff1_r <= pinIn[i];
                    ff2_r <= ff1_r;
                    ff3_r <= ff2_r;
                end
            end
            assign level[i] = ff2_r;
            assign rise[i]  = ff2_r & ~ff3_r;
        end
    endgenerate
endmodule

// file: core/rtb_stage4.v
`timescale 1ns/1ps
module rtb_stage4 (
    clk,
    rst,
    tick,
    count_enable_p,
    count_enable_t,
    load,
    preset,
    q,
    carry
);
    input  wire       clk;
    input  wire       rst;
    input  wire       tick;
    input  wire       count_enable_p;
    input  wire       count_enable_t;
    input  wire       load;
    input  wire [3:0] preset;
    output wire [3:0] q;
    output wire       carry;

    reg [3:0] q_r;

    // carry only at all ones with both enables
    assign carry = (q_r == 4'hF) & count_enable_p & count_enable_t;
    assign q     = q_r;

    always @(posedge clk) begin
        if (rst) begin
            q_r <= 4'h0;
        end else if (tick) begin
            if (load) begin
                q_r <= preset;
            end else if (count_enable_p & count_enable_t) begin
                q_r <= q_r + 4'h1;
            end
        end
    end
endmodule

// file: core/rtb_top.v
`timescale 1ns/1ps
`include "rtb_map.vh"

module rtb_top (
    clk,
    rst,
    extClkIn,
    oscInhibit,
    remoteVsyncIn_n,
    busInit,
    timePulseOne,
    timePulseThree,
    timePulseFour,
    intStrobe,
    loadStartAddressInstr,
    goDisplayInstr,
    priorityGranted,
    mode64,
    graphicMode,
    fiftyHz,
    dataIn,
    clkHalf_r,
    clkQuarter_r,
    charRate_r,
    hsync_r,
    vsync_r,
    horizontalDisplayZone_r,
    verticalDisplayZone_r,
    fiftyHzStagePreset_r,
    maintenanceGoFlag_r,
    countingFlag_r,
    breakRequestFlag_r,
    breakAddrFlagA_r,
    breakAddrFlagB_r,
    breakAddrFlagC_r,
    memoryAddressLines_r,
    extendedFieldLines_r,
    addressOe_r
);
    input  wire                  clk;
    input  wire                  rst;
    input  wire                  extClkIn;
    input  wire                  oscInhibit;
    input  wire                  remoteVsyncIn_n;
    input  wire                  busInit;
    input  wire                  timePulseOne;
    input  wire                  timePulseThree;
    input  wire                  timePulseFour;
    input  wire                  intStrobe;
    input  wire                  loadStartAddressInstr;
    input  wire                  goDisplayInstr;
    input  wire                  priorityGranted;
    input  wire                  mode64;
    input  wire                  graphicMode;
    input  wire                  fiftyHz;
    input  wire [`RTB_DATA_W-1:0] dataIn;
    output reg                   clkHalf_r;
    output reg                   clkQuarter_r;
    output reg                   charRate_r;
    output reg                   hsync_r;
    output reg                   vsync_r;
    output reg                   horizontalDisplayZone_r;
    output reg                   verticalDisplayZone_r;
    output reg                   fiftyHzStagePreset_r;
    output reg                   maintenanceGoFlag_r;
    output reg                   countingFlag_r;
    output reg                   breakRequestFlag_r;
    output reg                   breakAddrFlagA_r;
    output reg                   breakAddrFlagB_r;
    output reg                   breakAddrFlagC_r;
    output reg [11:0]            memoryAddressLines_r;
    output reg [2:0]             extendedFieldLines_r;
    output reg                   addressOe_r;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    wire [`RTB_PIN_COUNT-1:0] pinRaw;
    wire [`RTB_PIN_COUNT-1:0] pinLvl;
    wire [`RTB_PIN_COUNT-1:0] pinRise;
    wire [`RTB_DATA_W-1:0]    dataLvl;

    assign pinRaw = {fiftyHz, graphicMode, mode64, priorityGranted, goDisplayInstr,
                     loadStartAddressInstr, intStrobe, timePulseFour, timePulseThree,
                     timePulseOne, busInit, ~remoteVsyncIn_n, oscInhibit, extClkIn};

    rtb_pin_sync #(.W(`RTB_PIN_COUNT)) uPinSync (
        .clk   (clk),
        .rst   (rst),
        .pinIn (pinRaw),
        .level (pinLvl),
        .rise  (pinRise)
    );

    rtb_pin_sync #(.W(`RTB_DATA_W)) uDataSync (
        .clk   (clk),
        .rst   (rst),
        .pinIn (dataIn),
        .level (dataLvl),
        .rise  ()
    );

    wire initLvl     = pinLvl[`RTB_PIN_INIT];
    wire remoteSync  = pinLvl[`RTB_PIN_RVSYNC];
    wire tp1         = pinRise[`RTB_PIN_TP1];
    wire tp3         = pinRise[`RTB_PIN_TP3];
    wire tp4         = pinRise[`RTB_PIN_TP4];
    wire intStb      = pinRise[`RTB_PIN_INTSTB];
    wire iotLoad     = pinLvl[`RTB_PIN_IOTLOAD];
    wire iotGo       = pinLvl[`RTB_PIN_IOTGO];
    wire granted     = pinLvl[`RTB_PIN_GRANT];
    wire wide64      = pinLvl[`RTB_PIN_MODE64];
    wire graph       = pinLvl[`RTB_PIN_GRAPH];
    wire fifty       = pinLvl[`RTB_PIN_FIFTY];

    ////////////////////////////////////////////////////////////////////////
    // clock pulse generator
    // internal oscillator ticks every clk; test mode uses injected edges
    wire baseTick = pinLvl[`RTB_PIN_OSCINH] ? pinRise[`RTB_PIN_EXTCLK] : 1'b1;
    wire halfTick;
    wire quarterTick;
    reg  div2_r;
    reg  div4_r;

    assign halfTick    = baseTick & div2_r;
    assign quarterTick = halfTick & div4_r;

    always @(posedge clk) begin
        if (rst) begin
            div2_r       <= 1'b0;
            div4_r       <= 1'b0;
            clkHalf_r    <= 1'b0;
            clkQuarter_r <= 1'b0;
        end else begin
            if (baseTick) begin
                div2_r    <= ~div2_r;
                clkHalf_r <= ~div2_r;
            end
            if (halfTick) begin
                div4_r       <= ~div4_r;
                clkQuarter_r <= ~div4_r;
            end
        end
    end

    // faster phase for 64 characters per line
    wire stageTick = wide64 ? halfTick : quarterTick;

    ////////////////////////////////////////////////////////////////////////
    // divider chain
    wire [3:0] qChar;
    wire [3:0] qHalf;
    wire [3:0] qThird;
    wire [3:0] qLine;
    wire [3:0] qGroup;
    wire [3:0] qFrLow;
    wire [3:0] qFrHigh;
    wire       cChar;
    wire       cHalf;
    wire       cThird;
    wire       cLine;
    wire       cGroup;
    wire       cFrLow;
    wire       cFrHigh;
    wire       fiftyHit;
    wire       frontLoad;
    wire       backLoad;

    assign fiftyHit  = fifty & (qFrHigh == `RTB_FRHIGH50_HIT) & qGroup[3] & qFrLow[0]
                       & cLine;
    assign frontLoad = remoteSync | initLvl;
    assign backLoad  = remoteSync | fiftyHit;

    rtb_stage4 uCharRateStage (
        .clk    (clk),
        .rst    (rst),
        .tick   (stageTick),
        .count_enable_p    (1'b1),
        .count_enable_t    (1'b1),
        .load   (cChar | frontLoad),
        .preset (`RTB_PRE_CHAR),
        .q      (qChar),
        .carry  (cChar)
    );

    rtb_stage4 uHalvingStage (
        .clk    (clk),
        .rst    (rst),
        .tick   (stageTick),
        .count_enable_p    (1'b1),
        .count_enable_t    (cChar & wide64),
        .load   (cHalf | frontLoad),
        .preset (`RTB_PRE_HALF),
        .q      (qHalf),
        .carry  (cHalf)
    );

    rtb_stage4 uThirdDividerStage (
        .clk    (clk),
        .rst    (rst),
        .tick   (stageTick),
        .count_enable_p    (1'b1),
        .count_enable_t    (wide64 ? cHalf : cChar),
        .load   (cThird | frontLoad),
        .preset (`RTB_PRE_THIRD),
        .q      (qThird),
        .carry  (cThird)
    );

    rtb_stage4 uLineStage (
        .clk    (clk),
        .rst    (rst),
        .tick   (stageTick),
        .count_enable_p    (1'b1),
        .count_enable_t    (cThird),
        .load   (cLine | backLoad),
        .preset (`RTB_PRE_LINE),
        .q      (qLine),
        .carry  (cLine)
    );

    rtb_stage4 uLineGroupStage (
        .clk    (clk),
        .rst    (rst),
        .tick   (stageTick),
        .count_enable_p    (1'b1),
        .count_enable_t    (cLine),
        .load   (cGroup | backLoad),
        .preset (`RTB_PRE_GROUP),
        .q      (qGroup),
        .carry  (cGroup)
    );

    rtb_stage4 uFrameStageLow (
        .clk    (clk),
        .rst    (rst),
        .tick   (stageTick),
        .count_enable_p    (1'b1),
        .count_enable_t    (cGroup),
        .load   (cFrLow | backLoad),
        .preset (`RTB_PRE_FRLOW),
        .q      (qFrLow),
        .carry  (cFrLow)
    );

    // in 50 Hz the top stage reloads only through the preset line or remote sync
    rtb_stage4 uFrameStageHigh (
        .clk    (clk),
        .rst    (rst),
        .tick   (stageTick),
        .count_enable_p    (1'b1),
        .count_enable_t    (cFrLow),
        .load   ((cFrHigh & ~fifty) | backLoad),
        .preset (fifty ? `RTB_PRE_FRHIGH50 : `RTB_PRE_FRHIGH60),
        .q      (qFrHigh),
        .carry  (cFrHigh)
    );

    wire lineEvt  = stageTick & cLine;
    wire vsyncEvt = stageTick & (fifty ? fiftyHit : cFrHigh);

    ////////////////////////////////////////////////////////////////////////
    // sync and zone flops
    reg  [8:0] lineCnt_r;
    wire [8:0] vzEnd = `RTB_VZ_START + `RTB_VZ_LINES;
    wire [3:0] hzOff = graph ? `RTB_HZ_OFF_GRAPH : `RTB_HZ_OFF_ALPHA;

    always @(posedge clk) begin
        if (rst) begin
            charRate_r              <= 1'b0;
            hsync_r                 <= 1'b0;
            vsync_r                 <= 1'b0;
            fiftyHzStagePreset_r    <= 1'b0;
            lineCnt_r               <= 9'h000;
            verticalDisplayZone_r   <= 1'b0;
            horizontalDisplayZone_r <= 1'b0;
        end else begin
            if (stageTick) begin
                charRate_r <= qChar[0];
            end
            hsync_r              <= lineEvt;
            vsync_r              <= vsyncEvt;
            fiftyHzStagePreset_r <= stageTick & fiftyHit;
            if (vsyncEvt) begin
                lineCnt_r             <= 9'h000;
                verticalDisplayZone_r <= 1'b0;
            end else if (lineEvt) begin
                lineCnt_r <= lineCnt_r + 9'h001;
                // zone edges on line boundaries give exactly 200 lines
                if (lineCnt_r == `RTB_VZ_START) begin
                    verticalDisplayZone_r <= 1'b1;
                end else if (lineCnt_r == vzEnd) begin
                    verticalDisplayZone_r <= 1'b0;
                end
            end
            if (lineEvt) begin
                horizontalDisplayZone_r <= 1'b0;
            end else if (stageTick & cThird) begin
                if ((qLine == `RTB_HZ_ON) & verticalDisplayZone_r) begin
                    horizontalDisplayZone_r <= 1'b1;
                end else if (qLine == hzOff) begin
                    horizontalDisplayZone_r <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // start address registers and refresh counter
    reg  [11:0] refreshStartAddress_r;
    reg  [2:0]  refreshExtendedField_r;
    reg  [14:0] refreshCounter_r;
    wire        captureStartAddr = iotLoad & tp3;
    wire        captureExtField  = iotGo & tp3;
    wire        loadRefreshCounter = vsyncEvt & ~maintenanceGoFlag_r;
    wire        incrementRefreshCounter = tp4 & breakAddrFlagB_r & breakAddrFlagC_r;

    always @(posedge clk) begin
        if (rst) begin
            refreshStartAddress_r  <= 12'h000;
            refreshExtendedField_r <= 3'h0;
            refreshCounter_r       <= 15'h0000;
            maintenanceGoFlag_r    <= 1'b1;
        end else begin
            if (captureStartAddr) begin
                refreshStartAddress_r <= dataLvl;
            end
            if (captureExtField) begin
                refreshExtendedField_r <= dataLvl[`RTB_EXT_MSB:`RTB_EXT_LSB];
            end
            if (initLvl) begin
                maintenanceGoFlag_r <= 1'b1;
            end else if (captureExtField) begin
                maintenanceGoFlag_r <= 1'b0;
            end
            if (loadRefreshCounter) begin
                refreshCounter_r <= {refreshExtendedField_r, refreshStartAddress_r};
            end else if (incrementRefreshCounter) begin
                refreshCounter_r <= refreshCounter_r + 15'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // break burst trigger and tally
    reg        goAfterVsync_r;
    reg  [3:0] breakCounter_r;
    reg  [1:0] rowFlags_r;
    wire       burstAlpha = ~graph & cGroup;
    wire       burstGraph = graph & qGroup[0];
    wire       breakBurstTrigger = lineEvt & verticalDisplayZone_r & goAfterVsync_r
                                   & (burstAlpha | burstGraph);
    wire       breakTallyPulse = tp1 & breakAddrFlagA_r;
    wire [5:0] tallyNow = {rowFlags_r, breakCounter_r};
    wire [5:0] tallyLast = (wide64 & ~graph) ? `RTB_BRK_LAST64 : `RTB_BRK_LAST32;
    wire       tallyDone = breakTallyPulse & (tallyNow == tallyLast);

    always @(posedge clk) begin
        if (rst) begin
            goAfterVsync_r <= 1'b0;
            breakCounter_r <= 4'h0;
            rowFlags_r     <= 2'h0;
            countingFlag_r <= 1'b0;
        end else begin
            if (initLvl) begin
                goAfterVsync_r <= 1'b0;
            end else if (vsyncEvt) begin
                goAfterVsync_r <= ~maintenanceGoFlag_r;
            end
            if (vsyncEvt | initLvl) begin
                breakCounter_r <= 4'h0;
                rowFlags_r     <= 2'h0;
            end else if (breakTallyPulse) begin
                {rowFlags_r, breakCounter_r} <= tallyNow + 6'h01;
            end
            if (initLvl | vsyncEvt) begin
                countingFlag_r <= 1'b0;
            end else if (breakBurstTrigger) begin
                countingFlag_r <= 1'b1;
            end else if (tallyDone) begin
                countingFlag_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // break request and address flags
    always @(posedge clk) begin
        if (rst) begin
            breakRequestFlag_r <= 1'b0;
            breakAddrFlagA_r   <= 1'b0;
            breakAddrFlagB_r   <= 1'b0;
            breakAddrFlagC_r   <= 1'b0;
        end else if (initLvl) begin
            breakRequestFlag_r <= 1'b0;
            breakAddrFlagA_r   <= 1'b0;
            breakAddrFlagB_r   <= 1'b0;
            breakAddrFlagC_r   <= 1'b0;
        end else begin
            if (intStb) begin
                breakRequestFlag_r <= countingFlag_r & ~maintenanceGoFlag_r;
            end
            if (tp4) begin
                breakAddrFlagA_r <= breakRequestFlag_r & granted;
                breakAddrFlagB_r <= breakRequestFlag_r & granted;
                breakAddrFlagC_r <= 1'b0;
            end else if (tp1 & breakAddrFlagA_r) begin
                breakAddrFlagC_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address line drivers
    wire driveAddr = breakAddrFlagA_r & breakAddrFlagB_r;

    always @(posedge clk) begin
        if (rst) begin
            memoryAddressLines_r <= 12'h000;
            extendedFieldLines_r <= 3'h0;
            addressOe_r          <= 1'b0;
        end else begin
            addressOe_r          <= driveAddr;
            memoryAddressLines_r <= driveAddr ? refreshCounter_r[11:0] : 12'h000;
            extendedFieldLines_r <= driveAddr ? refreshCounter_r[14:12] : 3'h0;
        end
    end
endmodule

// file: verif/rtb_host_model.sv
`timescale 1ns/1ps
module rtb_host_model (
    input  wire logic        clk,
    output wire logic        timePulseOne,
    output wire logic        timePulseThree,
    output wire logic        timePulseFour,
    output wire logic        intStrobe,
    output      logic        loadStartAddressInstr = 1'b0,
    output      logic        goDisplayInstr        = 1'b0,
    output wire logic        priorityGranted,
    output      logic [11:0] dataIn                = 12'h000
);
    logic [3:0] pul = 4'h0;
    logic       grant = 1'b1;

    assign {intStrobe, timePulseFour, timePulseThree, timePulseOne} = pul;
    assign priorityGranted = grant;
    ////////////////////////////////////////////////////////////////////////////////
    // one pulse: 3 clk high, 3 clk low
    task automatic pulse(input logic [3:0] m);
        @(posedge clk);
        pul <= m;
        repeat (3) @(posedge clk);
        pul <= 4'h0;
        repeat (3) @(posedge clk);
    endtask

    // data settles before the third time pulse, inverted once released
    task automatic ioInstr(input logic go, input logic [11:0] d);
        @(posedge clk);
        dataIn <= d;
        loadStartAddressInstr <= !go;
        goDisplayInstr <= go;
        repeat (3) @(posedge clk);
        pulse(4'h2);
        loadStartAddressInstr <= 1'b0;
        goDisplayInstr <= 1'b0;
        dataIn <= ~d;
    endtask
endmodule

// file: verif/rtb_top_assertions.sv
`timescale 1ns/1ps
module rtb_top_assertions (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        busInit,
    input wire logic        goDisplayInstr,
    input wire logic        timePulseThree,
    input wire logic        hsync_r,
    input wire logic        vsync_r,
    input wire logic        horizontalDisplayZone_r,
    input wire logic        verticalDisplayZone_r,
    input wire logic        maintenanceGoFlag_r,
    input wire logic        countingFlag_r,
    input wire logic        breakRequestFlag_r,
    input wire logic        breakAddrFlagA_r,
    input wire logic        breakAddrFlagB_r,
    input wire logic        breakAddrFlagC_r,
    input wire logic [11:0] memoryAddressLines_r,
    input wire logic [2:0]  extendedFieldLines_r,
    input wire logic        addressOe_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    chk_addr_idle: assert property (!addressOe_r |->
        memoryAddressLines_r == 12'h000 && extendedFieldLines_r == 3'h0)
        else $error("address lines driven while idle");
    chk_oe_follow: assert property (
        addressOe_r == $past(breakAddrFlagA_r && breakAddrFlagB_r))
        else $error("address enable not following break flags");
    chk_hsync_pulse: assert property (hsync_r |=> !hsync_r)
        else $error("horizontal sync wider than one cycle");
    chk_zone_nest: assert property (horizontalDisplayZone_r |-> verticalDisplayZone_r)
        else $error("horizontal zone outside vertical zone");
    chk_vsync_quiet: assert property (vsync_r |-> !countingFlag_r)
        else $error("counting flag survived vertical sync");
    chk_req_cause: assert property ($rose(breakRequestFlag_r) |->
        $past(countingFlag_r) && !$past(maintenanceGoFlag_r))
        else $error("break request without counting");
    chk_third_after: assert property ($rose(breakAddrFlagC_r) |-> $past(breakAddrFlagA_r))
        else $error("third break flag set without first");
    chk_go_clear: assert property ($fell(maintenanceGoFlag_r) |->
        $past(goDisplayInstr, 2) && $past(timePulseThree, 2))
        else $error("maintenance flag cleared without go");
    chk_init_hold: assert property (busInit [*5] |-> maintenanceGoFlag_r
        && !countingFlag_r && !breakRequestFlag_r)
        else $error("init did not quiet break logic");
    cover property ($rose(countingFlag_r));
    cover property ($rose(addressOe_r));
    cover property (vsync_r);
endmodule
bind rtb_top rtb_top_assertions u_rtb_top_assertions (.clk, .rst, .busInit, .goDisplayInstr,
    .timePulseThree, .hsync_r, .vsync_r, .horizontalDisplayZone_r, .verticalDisplayZone_r,
    .maintenanceGoFlag_r, .countingFlag_r, .breakRequestFlag_r, .breakAddrFlagA_r,
    .breakAddrFlagB_r, .breakAddrFlagC_r, .memoryAddressLines_r, .extendedFieldLines_r,
    .addressOe_r);

// file: verif/rtb_top_tb.sv
`timescale 1ns/1ps
module rtb_top_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        remoteVsyncIn_n = 1'b1;
    logic        busInit = 1'b0;
    logic        graphicMode = 1'b0;
    logic        extClkIn = 1'b0;
    logic        oscInhibit = 1'b0;
    logic        mode64 = 1'b0;
    logic        fiftyHz = 1'b0;
    logic        halfSeen;
    wire         timePulseOne, timePulseThree, timePulseFour, intStrobe;
    wire         loadStartAddressInstr, goDisplayInstr, priorityGranted;
    wire  [11:0] dataIn;
    wire  [11:0] memoryAddressLines_r;
    wire  [2:0]  extendedFieldLines_r;
    wire         vsync_r, countingFlag_r, breakRequestFlag_r, addressOe_r, clkHalf_r;
    wire         maintenanceGoFlag_r;
    int          err_total = 0;
    int          comparisons = 0;
    int          n;

    always #10 clk = ~clk;

    rtb_host_model u_rtb_host_model (.clk, .timePulseOne, .timePulseThree, .timePulseFour,
        .intStrobe, .loadStartAddressInstr, .goDisplayInstr, .priorityGranted, .dataIn);

    rtb_top u_rtb_top (.clk, .rst, .extClkIn, .oscInhibit, .remoteVsyncIn_n,
        .busInit, .timePulseOne, .timePulseThree, .timePulseFour, .intStrobe,
        .loadStartAddressInstr, .goDisplayInstr, .priorityGranted, .mode64,
        .graphicMode, .fiftyHz, .dataIn, .clkHalf_r, .clkQuarter_r(),
        .charRate_r(), .hsync_r(), .vsync_r, .horizontalDisplayZone_r(),
        .verticalDisplayZone_r(), .fiftyHzStagePreset_r(), .maintenanceGoFlag_r,
        .countingFlag_r, .breakRequestFlag_r, .breakAddrFlagA_r(), .breakAddrFlagB_r(),
        .breakAddrFlagC_r(), .memoryAddressLines_r, .extendedFieldLines_r, .addressOe_r);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [14:0] got, input logic [14:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // bounded wait on counting flag (sel 1) or vertical sync (sel 0)
    task automatic waitHi(input logic sel, input int lim);
        int k;
        k = 0;
        while ((sel ? countingFlag_r : vsync_r) !== 1'b1 && k < lim) begin
            @(posedge clk);
            k++;
        end
        if (k >= lim) begin
            err_total++;
            end_sim;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        graphicMode <= 1'b1;
        remoteVsyncIn_n <= 1'b0;
        repeat (8) @(posedge clk);
        remoteVsyncIn_n <= 1'b1;
        check(15'(maintenanceGoFlag_r), 15'h0001);
        check(15'(countingFlag_r), 15'h0000);
        $display("test reset done");
        u_rtb_host_model.ioInstr(1'b0, 12'hFFE);
        u_rtb_host_model.ioInstr(1'b1, 12'h1C0);
        check(15'(maintenanceGoFlag_r), 15'h0000);
        waitHi(1'b0, 500000);
        waitHi(1'b1, 60000);
        $display("test load and go done");
        u_rtb_host_model.grant <= 1'b0;
        u_rtb_host_model.pulse(4'h8);
        u_rtb_host_model.pulse(4'h4);
        check(15'(addressOe_r), 15'h0000);
        u_rtb_host_model.grant <= 1'b1;
        n = 0;
        while (countingFlag_r === 1'b1 && n < 40) begin
            u_rtb_host_model.pulse(4'h8);
            u_rtb_host_model.pulse(4'h4);
            check({extendedFieldLines_r, memoryAddressLines_r}, 15'h7FFE + 15'(n));
            u_rtb_host_model.pulse(4'h1);
            n++;
        end
        check(15'(n), 15'h0020);
        u_rtb_host_model.pulse(4'h8);
        u_rtb_host_model.pulse(4'h4);
        check(15'(breakRequestFlag_r), 15'h0000);
        check(15'(addressOe_r), 15'h0000);
        check({extendedFieldLines_r, memoryAddressLines_r}, 15'h0000);
        $display("test break burst done");
        busInit <= 1'b1;
        repeat (6) @(posedge clk);
        check(15'(maintenanceGoFlag_r), 15'h0001);
        busInit <= 1'b0;
        $display("test init done");
        halfSeen = clkHalf_r;
        @(posedge clk);
        check(15'(clkHalf_r), 15'(!halfSeen));
        oscInhibit <= 1'b1;
        repeat (4) @(posedge clk);
        halfSeen = clkHalf_r;
        repeat (4) @(posedge clk);
        check(15'(clkHalf_r), 15'(halfSeen));
        extClkIn <= 1'b1;
        repeat (4) @(posedge clk);
        check(15'(clkHalf_r), 15'(!halfSeen));
        extClkIn <= 1'b0;
        oscInhibit <= 1'b0;
        $display("test clock source done");
        end_sim;
    end
endmodule
